// ==== common/dcl_core_if.sv ====
// Interface carrying power state between the sequencer and the top
`timescale 1ns/10ps
interface dcl_core_if;
  logic core_on;
  logic buf_on;
  logic ready;
  logic want_on;
  logic want_buf;
  modport seq (output core_on, output buf_on, output ready, input want_on, input want_buf);
  modport top (input core_on, input buf_on, input ready, output want_on, output want_buf);
endinterface : dcl_core_if

// ==== common/dcl_pkg.sv ====
// Package with register map, field positions and timing counts of the converter control
package dcl_pkg;
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_VALUE     = 8'h01;
  localparam logic [7:0] ADDR_STATUS    = 8'h02;
  localparam int         BIT_ENABLE     = 0;
  localparam int         BIT_PIN_BUF    = 6;
  localparam int         BIT_STBY_RUN   = 7;
  localparam logic [7:0] CONTROL_MASK   = 8'hc1;
  localparam logic [7:0] RESET_CONTROL  = 8'h00;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam int         STARTUP_NS     = 1000;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_COUNT  = 8'(STARTUP_CYCLES);
  typedef enum logic [1:0] {
    DCL_OFF,
    DCL_STARTUP,
    DCL_ACTIVE
  } dcl_state_type;
endpackage : dcl_pkg

// ==== core/dcl_control.sv ====
// Digital control of the 8-bit resistor-string converter
`timescale 1ns/10ps
module dcl_control (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       standby_sleep,
  input  wire logic       powerdown_sleep,
  input  wire logic       debug_halt,
  output logic            core_power,
  output logic            pin_buffer_on,
  output logic            internal_out_valid,
  output logic            convert_start,
  output logic      [7:0] convert_data
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] value;
    logic [7:0] rdata;
    logic       pending;
    logic       start;
    logic [7:0] data;
    logic       power;
    logic       buffer;
    logic       internal;
  } dcl_top_type;
  dcl_top_type st;
  dcl_top_type next_st;

  logic           stby_s;
  logic           pdown_s;
  logic           enabled;
  logic           allowed;
  logic           ctl_wr;
  logic           val_wr;
  logic     [7:0] new_ctl;
  dcl_core_if     pw ();

  // Sleep pins come from the power manager domain
  dcl_sync u_sync_stby (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (standby_sleep),
    .dout     (stby_s)
  );

  dcl_sync u_sync_pdown (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (powerdown_sleep),
    .dout     (pdown_s)
  );

  dcl_power_seq u_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .pw       (pw)
  );

  // Decode and power request; debug halt is deliberately not used
  always_comb begin
    ctl_wr  = reg_write && (reg_addr == dcl_pkg::ADDR_CONTROL);
    val_wr  = reg_write && (reg_addr == dcl_pkg::ADDR_VALUE);
    new_ctl = reg_wdata & dcl_pkg::CONTROL_MASK;
    enabled = st.control[dcl_pkg::BIT_ENABLE];
    allowed = !pdown_s && (!stby_s || st.control[dcl_pkg::BIT_STBY_RUN]);
    pw.want_on  = enabled && allowed;
    pw.want_buf = st.control[dcl_pkg::BIT_PIN_BUF];
  end

  // Register file, conversion scheduling and output flops
  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    if (ctl_wr) begin
      next_st.control = new_ctl;
      if (new_ctl[dcl_pkg::BIT_ENABLE] && !enabled) begin
        next_st.pending = 1'b1;
      end
      if (!new_ctl[dcl_pkg::BIT_ENABLE]) begin
        next_st.pending = 1'b0;
      end
    end
    if (val_wr) begin
      next_st.value = reg_wdata;
      if (enabled) begin
        next_st.pending = 1'b1;
      end
    end
    // Fire a pending conversion once the core is powered and settled
    if (st.pending && pw.ready && !val_wr) begin
      next_st.start   = 1'b1;
      next_st.data    = st.value;
      next_st.pending = 1'b0;
    end
    // Losing power mid-stream means the core must convert again on wake
    if (!pw.want_on && enabled) begin
      next_st.pending = 1'b1;
    end
    next_st.power    = pw.core_on;
    next_st.buffer   = pw.buf_on;
    next_st.internal = pw.ready;
    // Read data for the next cycle
    if (reg_read) begin
      case (reg_addr)
        dcl_pkg::ADDR_CONTROL: next_st.rdata = st.control;
        dcl_pkg::ADDR_VALUE:   next_st.rdata = st.value;
        dcl_pkg::ADDR_STATUS:  next_st.rdata = {5'h00, pw.buf_on, pw.ready, pw.core_on};
        default:               next_st.rdata = 8'h00;
      endcase
    end else begin
      next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st         <= '0;
      st.control <= dcl_pkg::RESET_CONTROL;
      st.value   <= dcl_pkg::RESET_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata          = st.rdata;
  assign core_power         = st.power;
  assign pin_buffer_on      = st.buffer;
  assign internal_out_valid = st.internal;
  assign convert_start      = st.start;
  assign convert_data       = st.data;

  // Named steps of a conversion request
  sequence s_value_write_enabled;
    val_wr && enabled && pw.ready;
  endsequence

  sequence s_start_seen;
    ##[1:3] convert_start;
  endsequence

  a_write_starts_conv: assert property (@(posedge core_clk) disable iff (rst)
    s_value_write_enabled |-> s_start_seen)
    else $error("enabled value write did not start a conversion");

  a_disabled_no_start: assert property (@(posedge core_clk) disable iff (rst)
    (val_wr && !enabled && !ctl_wr) |=> !st.pending)
    else $error("disabled value write scheduled a conversion");

  a_enable_bit_store: assert property (@(posedge core_clk) disable iff (rst)
    ctl_wr |=> st.control[0] == $past(reg_wdata[0]))
    else $error("enable bit not stored");

  a_buffer_follows: assert property (@(posedge core_clk) disable iff (rst)
    pin_buffer_on |-> st.control[dcl_pkg::BIT_PIN_BUF] || $past(st.control[dcl_pkg::BIT_PIN_BUF]))
    else $error("buffer on without pin buffer enable");

  a_internal_needs_en: assert property (@(posedge core_clk) disable iff (rst)
    internal_out_valid |-> core_power)
    else $error("internal output offered while core off");

  a_powerdown_off: assert property (@(posedge core_clk) disable iff (rst)
    pdown_s [*3] |-> !core_power && !pin_buffer_on)
    else $error("core powered during power-down");

  a_standby_off: assert property (@(posedge core_clk) disable iff (rst)
    (stby_s && !st.control[dcl_pkg::BIT_STBY_RUN]) [*3] |-> !core_power)
    else $error("core powered in standby without run enable");

  a_start_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    convert_start |=> !convert_start)
    else $error("conversion start longer than one cycle");

  a_start_data_match: assert property (@(posedge core_clk) disable iff (rst)
    convert_start |-> convert_data == $past(st.value))
    else $error("converted data differs from value register");
endmodule : dcl_control

// ==== core/dcl_power_seq.sv ====
// Power sequencer: analog core and buffer power with start-up interval
`timescale 1ns/10ps
module dcl_power_seq (
  input  wire logic  core_clk,
  input  wire logic  rst,
  dcl_core_if.seq    pw
);
  typedef struct packed {
    dcl_pkg::dcl_state_type state;
    logic [7:0]             cnt;
  } dcl_seq_type;
  dcl_seq_type st;
  dcl_seq_type next_st;

  // Power up, wait start-up, then report ready; drop at once when not wanted
  always_comb begin
    next_st = st;
    case (st.state)
      dcl_pkg::DCL_OFF: begin
        if (pw.want_on) begin
          next_st.state = dcl_pkg::DCL_STARTUP;
          next_st.cnt   = dcl_pkg::STARTUP_COUNT;
        end
      end
      dcl_pkg::DCL_STARTUP: begin
        if (!pw.want_on) begin
          next_st.state = dcl_pkg::DCL_OFF;
        end else if (st.cnt <= 8'h01) begin
          next_st.state = dcl_pkg::DCL_ACTIVE;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      dcl_pkg::DCL_ACTIVE: begin
        if (!pw.want_on) begin
          next_st.state = dcl_pkg::DCL_OFF;
        end
      end
      default: begin
        next_st.state = dcl_pkg::DCL_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '{state: dcl_pkg::DCL_OFF, cnt: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign pw.core_on = (st.state != dcl_pkg::DCL_OFF);
  assign pw.buf_on  = (st.state != dcl_pkg::DCL_OFF) && pw.want_buf;
  assign pw.ready   = (st.state == dcl_pkg::DCL_ACTIVE);
endmodule : dcl_power_seq

// ==== core/dcl_sync.sv ====
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module dcl_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta;
    logic sync;
  } dcl_sync_type;
  dcl_sync_type st;
  dcl_sync_type next_st;

  // Shift the input through two stages
  always_comb begin
    next_st.meta = din;
    next_st.sync = st.meta;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.sync;
endmodule : dcl_sync

// ==== tb/dcl_analog_model.sv ====
// Behavioural analog core and output buffer of the converter
`timescale 1ns/10ps
module dcl_analog_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       core_power,
  input  wire logic       pin_buffer_on,
  input  wire logic       convert_start,
  input  wire logic [7:0] convert_data,
  output logic      [7:0] level,
  output logic      [7:0] pin_level,
  output int              starts
);
  // Latch value on a start while powered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level  <= 8'h00;
      starts <= 0;
    end else if (convert_start && core_power) begin
      level  <= convert_data;
      starts <= starts + 1;
    end
  end
  // Undriven pin shows inverse of last level
  assign pin_level = (pin_buffer_on && core_power) ? level : ~level;
endmodule : dcl_analog_model

// ==== tb/dcl_control_tb.sv ====
// Self-checking testbench of the converter control
`timescale 1ns/10ps
module dcl_control_tb;
  logic       core_clk = 0;
  logic       rst = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 0;
  logic       reg_read = 0;
  logic [7:0] reg_rdata;
  logic       stby = 0;
  logic       pdown = 0;
  logic       dbg = 0;
  logic       core_power;
  logic       pin_buffer_on;
  logic       out_valid;
  logic       convert_start;
  logic [7:0] convert_data;
  logic [7:0] level;
  logic [7:0] pin_level;
  int         starts;
  int         fails = 0;
  int         n_checks = 0;
  int         n;
  logic [7:0] d;
  // Clock of 10 ns
  always #5 core_clk = ~core_clk;
  dcl_control dcl_control_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .standby_sleep(stby),
    .powerdown_sleep(pdown), .debug_halt(dbg), .core_power(core_power), .pin_buffer_on(pin_buffer_on),
    .internal_out_valid(out_valid), .convert_start(convert_start), .convert_data(convert_data));
  dcl_analog_model dcl_analog_model_i (.core_clk(core_clk), .rst(rst), .core_power(core_power),
    .pin_buffer_on(pin_buffer_on), .convert_start(convert_start), .convert_data(convert_data),
    .level(level), .pin_level(pin_level), .starts(starts));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1;
    @(posedge core_clk);
    reg_write <= 0;
  endtask : wr
  // Read data stand in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge core_clk);
    reg_read <= 0;
    #1 v = reg_rdata;
  endtask : rd
  // Bounded wait for a start pulse
  task automatic ws(input int bound, output int c);
    c = 0;
    while (convert_start !== 1'b1) begin
      @(posedge core_clk);
      #1 c++;
      if (c >= bound) begin
        fails++;
        $display("start wait ran out");
        give_verdict();
      end
    end
  endtask : ws
  task automatic t_reset;
    rd(dcl_pkg::ADDR_CONTROL, d); chk(d, 8'h00);
    rd(dcl_pkg::ADDR_VALUE, d); chk(d, 8'h00);
    rd(8'h05, d); chk(d, 8'h00);
    chk(core_power, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_store;
    wr(dcl_pkg::ADDR_VALUE, 8'h5a);
    repeat (20) @(posedge core_clk);
    #1 chk(8'(starts), 8'h00);
    rd(dcl_pkg::ADDR_VALUE, d); chk(d, 8'h5a);
    wr(dcl_pkg::ADDR_CONTROL, 8'h01);
    ws(150, n);
    chk(convert_data, 8'h5a);
    chk(core_power, 1);
    chk(out_valid, 1);
    chk(pin_buffer_on, 0);
    @(posedge core_clk);
    #1 chk(convert_start, 0);
    chk(level, 8'h5a);
    chk(pin_level, 8'ha5);
    rd(dcl_pkg::ADDR_STATUS, d); chk(d, 8'h03);
    $display("store test done");
  endtask : t_store
  task automatic t_live;
    wr(dcl_pkg::ADDR_CONTROL, 8'h7f);
    rd(dcl_pkg::ADDR_CONTROL, d); chk(d, 8'h41);
    chk(pin_buffer_on, 1);
    chk(pin_level, 8'h5a);
    wr(dcl_pkg::ADDR_VALUE, 8'hff);
    ws(6, n);
    chk(n <= 2, 1);
    chk(convert_data, 8'hff);
    dbg <= 1;
    wr(dcl_pkg::ADDR_VALUE, 8'h00);
    wr(dcl_pkg::ADDR_VALUE, 8'h81);
    repeat (4) @(posedge core_clk);
    #1 chk(convert_data, 8'h81);
    chk(level, 8'h81);
    chk(core_power, 1);
    dbg <= 0;
    $display("live test done");
  endtask : t_live
  task automatic t_stby;
    wr(dcl_pkg::ADDR_CONTROL, 8'hc1);
    stby <= 1;
    repeat (6) @(posedge core_clk);
    #1 chk(core_power, 1);
    chk(pin_buffer_on, 1);
    wr(dcl_pkg::ADDR_VALUE, 8'h3c);
    ws(6, n);
    chk(convert_data, 8'h3c);
    stby <= 0;
    wr(dcl_pkg::ADDR_CONTROL, 8'h41);
    stby <= 1;
    repeat (6) @(posedge core_clk);
    #1 chk(core_power, 0);
    chk(pin_buffer_on, 0);
    stby <= 0;
    ws(150, n);
    chk(n >= dcl_pkg::STARTUP_CYCLES, 1);
    chk(convert_data, 8'h3c);
    chk(pin_buffer_on, 1);
    $display("standby test done");
  endtask : t_stby
  task automatic t_pdown;
    wr(dcl_pkg::ADDR_CONTROL, 8'hc1);
    pdown <= 1;
    repeat (6) @(posedge core_clk);
    #1 chk(core_power, 0);
    chk(pin_buffer_on, 0);
    pdown <= 0;
    ws(150, n);
    wr(dcl_pkg::ADDR_CONTROL, 8'h00);
    repeat (4) @(posedge core_clk);
    #1 chk(core_power, 0);
    chk(out_valid, 0);
    $display("power-down test done");
  endtask : t_pdown
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 0;
    t_reset();
    t_store();
    t_live();
    t_stby();
    t_pdown();
    give_verdict();
  end
endmodule : dcl_control_tb
